// *** logic/timer_params.svh ***
// register offsets, field positions and reset values of the timer channel core
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ------------------------------------------------------------
// byte register offsets on the register port
// ------------------------------------------------------------
`define OFS_COUNT_LO 5'h00
`define OFS_COUNT_HI 5'h01
`define OFS_CMP_A_LO 5'h02
`define OFS_CMP_A_HI 5'h03
`define OFS_CMP_B_LO 5'h04
`define OFS_CMP_B_HI 5'h05
`define OFS_BUF_A_LO 5'h06
`define OFS_BUF_A_HI 5'h07
`define OFS_BUF_B_LO 5'h08
`define OFS_BUF_B_HI 5'h09
`define OFS_OUT_CTRL_A 5'h0A
`define OFS_OUT_CTRL_B 5'h0B
`define OFS_PHASE_SEL 5'h0C
`define OFS_MODE 5'h0D
`define OFS_MATCH_CTRL 5'h0E
`define OFS_CLEAR_SEL 5'h0F
`define OFS_STATUS 5'h10

// ------------------------------------------------------------
// word port selects (16-bit access only)
// ------------------------------------------------------------
`define WSEL_CMP_A 2'h0
`define WSEL_CMP_B 2'h1
`define WSEL_BUF_A 2'h2
`define WSEL_BUF_B 2'h3

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define MODE_RUN 0
`define MODE_MATCH_A_EN 1
`define MODE_MATCH_B_EN 2
`define MODE_CASCADE 3
`define CTRL_AUTO_CLEAR_EN 0
`define CTRL_AUTO_CLEAR_SRC 1
`define CTRL_EVENT_A_EN 2
`define CTRL_EVENT_B_EN 3
`define CLRSEL_TRIGGER 4
`define OUT_INIT_LSB 0
`define OUT_MATCH_LSB 2
`define OUT_CLEAR_LSB 4
`define PHASE_SEL_A 0
`define PHASE_SEL_B 1
`define STAT_MATCH_A 0
`define STAT_MATCH_B 1
`define STAT_OVERFLOW 2

// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hFFFF
`define BYTE_RESET 8'h00

`endif

// *** logic/timer_pkg.sv ***
// types shared by the timer channel core and its output level stage
package timer_pkg;

    // 2-bit output action encoding
    typedef enum logic [1:0] {
        ACT_HOLD = 2'b00,
        ACT_LOW = 2'b01,
        ACT_HIGH = 2'b10,
        ACT_TOGGLE = 2'b11
    } out_action_t;

    typedef struct packed {
        logic level;
    } pin_state_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] buf_a;
        logic [15:0] buf_b;
        logic [7:0] wr_latch;
        logic [7:0] rd_latch;
        logic [3:0] mode;
        logic [3:0] match_ctrl;
        logic [4:0] clear_sel;
        logic [3:0] out_ctrl_a;
        logic [3:0] out_ctrl_b;
        logic [1:0] phase_sel;
        logic [2:0] status;
        logic [7:0] rdata;
        logic [15:0] word_rdata;
        logic event_a;
        logic event_b;
        logic carry_out;
        logic phase_a;
        logic phase_b;
    } core_state_t;

endpackage

// *** logic/output_level.sv ***
// one compare-driven output pin level with fixed event priority
`timescale 1ns/1ps
`default_nettype none

module output_level
    import timer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic init_wr,
    input wire logic [1:0] init_act,
    input wire logic clear_hit,
    input wire logic [1:0] clear_act,
    input wire logic match_hit,
    input wire logic [1:0] match_act,
    output logic pin_level
);

    pin_state_t state_q;
    pin_state_t state_d;

    // apply one action code to the present level
    function automatic logic apply_action(input logic [1:0] act, input logic cur);
        unique case (out_action_t'(act))
            ACT_HOLD: apply_action = cur;
            ACT_LOW: apply_action = 1'b0;
            ACT_HIGH: apply_action = 1'b1;
            ACT_TOGGLE: apply_action = ~cur;
        endcase
    endfunction

    // ------------------------------------------------------------
    // level priority
    // ------------------------------------------------------------
    // init write other than toggle beats clear/overflow, which beats the match action
    always_comb begin
        state_d = state_q;
        if (init_wr && (init_act != ACT_TOGGLE)) begin
            state_d.level = apply_action(init_act, state_q.level);
        end else if (clear_hit) begin
            state_d.level = apply_action(clear_act, state_q.level);
        end else if (match_hit) begin
            state_d.level = apply_action(match_act, state_q.level);
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign pin_level = state_q.level;

endmodule

`default_nettype wire

// *** logic/timer_counter_compare_core.sv ***
// 16-bit timer channel: counter, compare A/B, output pins, clear sources, cascade
`timescale 1ns/1ps
`default_nettype none
`include "timer_params.svh"

module timer_counter_compare_core
    import timer_pkg::*;
#(
    parameter int CHANNEL = 0
)
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] word_sel,
    input wire logic [15:0] word_wdata,
    input wire logic word_wr,
    input wire logic word_rd,
    output logic [15:0] word_rdata,
    input wire logic count_step,
    input wire logic count_down,
    input wire logic [3:0] pwm_clear_event,
    input wire logic trigger_input,
    input wire logic cascade_carry_in,
    input wire logic pin_a_in,
    input wire logic pin_b_in,
    input wire logic [5:0] comparator_out,
    output logic io_pin_a,
    output logic io_pin_b,
    output logic event_a,
    output logic event_b,
    output logic cascade_carry_out,
    output logic phase_a_src,
    output logic phase_b_src
);

    core_state_t st_q;
    core_state_t st_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // byte write strobe for one register offset
    function automatic logic wr_at(input logic [4:0] ofs);
        wr_at = reg_wr && (reg_addr == ofs);
    endfunction

    // word write strobe for one compare/buffer word
    function automatic logic word_wr_at(input logic [1:0] sel);
        word_wr_at = word_wr && (word_sel == sel);
    endfunction

    // comparator feeding input A (b=0) or B (b=1); channel 1 has none
    function automatic logic [2:0] comp_index(input int ch, input logic b);
        unique case (ch)
            0: comp_index = b ? 3'h5 : 3'h4;
            2: comp_index = b ? 3'h1 : 3'h0;
            3: comp_index = b ? 3'h3 : 3'h2;
            default: comp_index = 3'h0;
        endcase
    endfunction

    localparam logic HAS_COMP = (CHANNEL != 1);
    localparam logic [2:0] COMP_A = comp_index(CHANNEL, 1'b0);
    localparam logic [2:0] COMP_B = comp_index(CHANNEL, 1'b1);

    logic step;
    logic hit_a;
    logic hit_b;
    logic auto_clr;
    logic ext_clr;
    logic any_clr;
    logic wrap;
    logic cnt_wr;
    logic [2:0] stat_clr;
    logic [2:0] stat_set;

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    // upper half of a cascade steps on the lower half's carry only
    always_comb begin
        step = st_q.mode[`MODE_RUN] && (st_q.mode[`MODE_CASCADE] ? cascade_carry_in
                                                                 : count_step);
        // equality judged against the counter before this update
        hit_a = step && st_q.mode[`MODE_MATCH_A_EN] && (st_q.count == st_q.cmp_a);
        hit_b = step && st_q.mode[`MODE_MATCH_B_EN] && (st_q.count == st_q.cmp_b);
        auto_clr = st_q.match_ctrl[`CTRL_AUTO_CLEAR_EN]
                   && (st_q.match_ctrl[`CTRL_AUTO_CLEAR_SRC] ? hit_b : hit_a);
        // external clears act on any fast clock cycle, not just step cycles
        ext_clr = (|(pwm_clear_event & st_q.clear_sel[3:0]))
                  || (st_q.clear_sel[`CLRSEL_TRIGGER] && trigger_input);
        any_clr = auto_clr || ext_clr;
        wrap = step && !any_clr && !count_down && (st_q.count == `COUNT_MAX);
        cnt_wr = wr_at(`OFS_COUNT_HI);
        stat_set = '0;
        stat_set[`STAT_MATCH_A] = hit_a;
        stat_set[`STAT_MATCH_B] = hit_b;
        stat_set[`STAT_OVERFLOW] = wrap;
        stat_clr = wr_at(`OFS_STATUS) ? reg_wdata[2:0] : 3'h0;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.event_a = hit_a && st_q.match_ctrl[`CTRL_EVENT_A_EN];
        st_d.event_b = hit_b && st_q.match_ctrl[`CTRL_EVENT_B_EN];
        st_d.carry_out = wrap;

        // counter: software write, then clear, then step
        if (cnt_wr) begin
            st_d.count = {reg_wdata, st_q.wr_latch};
        end else if (any_clr) begin
            st_d.count = `COUNT_RESET;
        end else if (step) begin
            st_d.count = count_down ? st_q.count - 16'h0001 : st_q.count + 16'h0001;
        end

        // a low byte write of any word goes to the shared write latch
        if (wr_at(`OFS_COUNT_LO) || wr_at(`OFS_CMP_A_LO) || wr_at(`OFS_CMP_B_LO)
            || wr_at(`OFS_BUF_A_LO) || wr_at(`OFS_BUF_B_LO)) begin
            st_d.wr_latch = reg_wdata;
        end
        // compare writes land after this cycle's match used the old value
        if (wr_at(`OFS_CMP_A_HI)) begin
            st_d.cmp_a = {reg_wdata, st_q.wr_latch};
        end else if (word_wr_at(`WSEL_CMP_A)) begin
            st_d.cmp_a = word_wdata;
        end
        if (wr_at(`OFS_CMP_B_HI)) begin
            st_d.cmp_b = {reg_wdata, st_q.wr_latch};
        end else if (word_wr_at(`WSEL_CMP_B)) begin
            st_d.cmp_b = word_wdata;
        end
        if (wr_at(`OFS_BUF_A_HI)) begin
            st_d.buf_a = {reg_wdata, st_q.wr_latch};
        end else if (word_wr_at(`WSEL_BUF_A)) begin
            st_d.buf_a = word_wdata;
        end
        if (wr_at(`OFS_BUF_B_HI)) begin
            st_d.buf_b = {reg_wdata, st_q.wr_latch};
        end else if (word_wr_at(`WSEL_BUF_B)) begin
            st_d.buf_b = word_wdata;
        end

        // control registers; init level bits are not stored
        if (wr_at(`OFS_MODE)) begin
            st_d.mode = reg_wdata[3:0];
        end
        if (wr_at(`OFS_MATCH_CTRL)) begin
            st_d.match_ctrl = reg_wdata[3:0];
        end
        if (wr_at(`OFS_CLEAR_SEL)) begin
            st_d.clear_sel = reg_wdata[4:0];
        end
        if (wr_at(`OFS_OUT_CTRL_A)) begin
            st_d.out_ctrl_a = reg_wdata[5:2];
        end
        if (wr_at(`OFS_OUT_CTRL_B)) begin
            st_d.out_ctrl_b = reg_wdata[5:2];
        end
        if (wr_at(`OFS_PHASE_SEL)) begin
            st_d.phase_sel = reg_wdata[1:0];
        end

        // sticky flags: a set in the clearing cycle survives
        st_d.status = (st_q.status & ~stat_clr) | stat_set;

        // byte reads; low byte reads freeze the high byte
        if (reg_rd) begin
            unique case (reg_addr)
                `OFS_COUNT_LO: begin
                    st_d.rdata = st_q.count[7:0];
                    st_d.rd_latch = st_q.count[15:8];
                end
                `OFS_CMP_A_LO: begin
                    st_d.rdata = st_q.cmp_a[7:0];
                    st_d.rd_latch = st_q.cmp_a[15:8];
                end
                `OFS_CMP_B_LO: begin
                    st_d.rdata = st_q.cmp_b[7:0];
                    st_d.rd_latch = st_q.cmp_b[15:8];
                end
                `OFS_BUF_A_LO: begin
                    st_d.rdata = st_q.buf_a[7:0];
                    st_d.rd_latch = st_q.buf_a[15:8];
                end
                `OFS_BUF_B_LO: begin
                    st_d.rdata = st_q.buf_b[7:0];
                    st_d.rd_latch = st_q.buf_b[15:8];
                end
                `OFS_COUNT_HI, `OFS_CMP_A_HI, `OFS_CMP_B_HI,
                `OFS_BUF_A_HI, `OFS_BUF_B_HI: st_d.rdata = st_q.rd_latch;
                `OFS_OUT_CTRL_A: st_d.rdata = {2'b00, st_q.out_ctrl_a, 2'b00};
                `OFS_OUT_CTRL_B: st_d.rdata = {2'b00, st_q.out_ctrl_b, 2'b00};
                `OFS_PHASE_SEL: st_d.rdata = {6'h00, st_q.phase_sel};
                `OFS_MODE: st_d.rdata = {4'h0, st_q.mode};
                `OFS_MATCH_CTRL: st_d.rdata = {4'h0, st_q.match_ctrl};
                `OFS_CLEAR_SEL: st_d.rdata = {3'h0, st_q.clear_sel};
                `OFS_STATUS: st_d.rdata = {5'h00, st_q.status};
                default: st_d.rdata = `BYTE_RESET;
            endcase
        end

        // word reads return the live value, no latch
        if (word_rd) begin
            unique case (word_sel)
                `WSEL_CMP_A: st_d.word_rdata = st_q.cmp_a;
                `WSEL_CMP_B: st_d.word_rdata = st_q.cmp_b;
                `WSEL_BUF_A: st_d.word_rdata = st_q.buf_a;
                `WSEL_BUF_B: st_d.word_rdata = st_q.buf_b;
            endcase
        end

        // phase inputs; channel 1 has no comparator and keeps its pins
        st_d.phase_a = (HAS_COMP && st_q.phase_sel[`PHASE_SEL_A])
                       ? comparator_out[COMP_A] : pin_a_in;
        st_d.phase_b = (HAS_COMP && st_q.phase_sel[`PHASE_SEL_B])
                       ? comparator_out[COMP_B] : pin_b_in;
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0; // count starts at zero
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    // clear action also fires on overflow wrap; a clear that loses to a counter write still counts as clear
    output_level pin_a_level (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .init_wr(wr_at(`OFS_OUT_CTRL_A)),
        .init_act(reg_wdata[`OUT_INIT_LSB +: 2]),
        .clear_hit(any_clr || wrap),
        .clear_act(st_q.out_ctrl_a[3:2]),
        .match_hit(hit_a),
        .match_act(st_q.out_ctrl_a[1:0]),
        .pin_level(io_pin_a)
    );

    output_level pin_b_level (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .init_wr(wr_at(`OFS_OUT_CTRL_B)),
        .init_act(reg_wdata[`OUT_INIT_LSB +: 2]),
        .clear_hit(any_clr || wrap),
        .clear_act(st_q.out_ctrl_b[3:2]),
        .match_hit(hit_b),
        .match_act(st_q.out_ctrl_b[1:0]),
        .pin_level(io_pin_b)
    );

    assign reg_rdata = st_q.rdata;
    assign word_rdata = st_q.word_rdata;
    assign event_a = st_q.event_a;
    assign event_b = st_q.event_b;
    assign cascade_carry_out = st_q.carry_out;
    assign phase_a_src = st_q.phase_a;
    assign phase_b_src = st_q.phase_b;

endmodule

`default_nettype wire

// *** tb/timer_core_properties.sv ***
// port assertions and covers for the timer channel core
`timescale 1ns/1ps
`default_nettype none
`include "timer_params.svh"

module timer_core_properties (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic word_rd,
    input wire logic [15:0] word_rdata,
    input wire logic count_step,
    input wire logic count_down,
    input wire logic cascade_carry_in,
    input wire logic [3:0] pwm_clear_event,
    input wire logic trigger_input,
    input wire logic io_pin_a,
    input wire logic io_pin_b,
    input wire logic event_a,
    input wire logic event_b,
    input wire logic cascade_carry_out
);
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // run and cascade bits are internal, so either step source counts as a step
    logic any_step;
    assign any_step = count_step | cascade_carry_in;

    chk_event_a_cause: assert property (event_a |-> $past(any_step))
        else $error("event a without a count step");
    chk_event_b_cause: assert property (event_b |-> $past(any_step))
        else $error("event b without a count step");
    chk_carry_wrap: assert property (cascade_carry_out |-> $past(any_step) && !$past(count_down))
        else $error("carry out without an up step");
    chk_rdata_held: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("byte read data moved without a read");
    chk_word_held: assert property (!$past(word_rd) |-> $stable(word_rdata))
        else $error("word read data moved without a read");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > `OFS_STATUS |=> reg_rdata == 8'h00)
        else $error("unmapped offset read not zero");
    chk_init_low_a: assert property (reg_wr && reg_addr == `OFS_OUT_CTRL_A
        && reg_wdata[1:0] == 2'b01 |-> ##[1:2] !io_pin_a)
        else $error("pin a ignored initial low");
    chk_init_high_b: assert property (reg_wr && reg_addr == `OFS_OUT_CTRL_B
        && reg_wdata[1:0] == 2'b10 |-> ##[1:2] io_pin_b)
        else $error("pin b ignored initial high");
    chk_init_reads_zero: assert property (reg_rd && (reg_addr == `OFS_OUT_CTRL_A
        || reg_addr == `OFS_OUT_CTRL_B) |=> reg_rdata[1:0] == 2'b00)
        else $error("initial level field read back");
    chk_pin_cause: assert property ($changed(io_pin_a)
        |-> $past(reg_wr | any_step | trigger_input | (|pwm_clear_event)))
        else $error("pin a moved without a cause");

    cover property (event_a);
    cover property (event_b);
    cover property (cascade_carry_out);
endmodule

bind timer_counter_compare_core timer_core_properties chk (
    .ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .word_rd,
    .word_rdata, .count_step, .count_down, .cascade_carry_in, .pwm_clear_event,
    .trigger_input, .io_pin_a, .io_pin_b, .event_a, .event_b, .cascade_carry_out
);
`default_nettype wire

// *** tb/step_source.sv ***
// prescaler model: one count enable pulse every div fast clock cycles
`timescale 1ns/1ps
`default_nettype none

module step_source #(
    parameter int DIV = 4
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic run,
    output logic count_step
);
    // ----------------------------------------
    // divider
    // ----------------------------------------
    int cnt;

    // quiet while run is low, so the bench can freeze the count at will
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            count_step <= 1'b0;
        end else begin
            cnt <= (run && cnt < DIV - 1) ? cnt + 1 : 0;
            count_step <= run && cnt == DIV - 1;
        end
    end
endmodule
`default_nettype wire

// *** tb/timer_counter_compare_core_test.sv ***
// self-checking bench for the timer channel core
`timescale 1ns/1ps
`default_nettype none
`include "timer_params.svh"

module timer_counter_compare_core_test;
    logic ref_clk, rst_b, reg_wr, reg_rd, word_wr, word_rd, count_down, count_step;
    logic trigger_input, cascade_carry_in, pin_a_in, pin_b_in, run_steps;
    logic io_pin_a, io_pin_b, event_a, event_b, cascade_carry_out, phase_a_src, phase_b_src;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] word_sel;
    logic [15:0] word_wdata, word_rdata, got;
    logic [3:0] pwm_clear_event;
    logic [5:0] comparator_out;
    int num_errors = 0;
    int num_checks = 0;
    int n_ev_a = 0;

    // ----------------------------------------
    // instances, clock, monitors
    // ----------------------------------------
    timer_counter_compare_core #(.CHANNEL(0)) dut (
        .ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .word_sel,
        .word_wdata, .word_wr, .word_rd, .word_rdata, .count_step, .count_down,
        .pwm_clear_event, .trigger_input, .cascade_carry_in, .pin_a_in, .pin_b_in,
        .comparator_out, .io_pin_a, .io_pin_b, .event_a, .event_b, .cascade_carry_out,
        .phase_a_src, .phase_b_src
    );
    step_source #(.DIV(4)) prescaler (.ref_clk, .rst_b, .run(run_steps), .count_step);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // event a pulses counted for the compare walk
    always @(posedge ref_clk) if (event_a === 1'b1) n_ev_a <= n_ev_a + 1;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // every access ends one idle edge later, so strobes never retoggle in one step
    task automatic wr8(input logic [4:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
        @(posedge ref_clk) #1;
    endtask

    task automatic rd8(input logic [4:0] a, input logic [7:0] e, input string what);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk) #1;
        reg_rd = 1'b0;
        cmp(what, {8'h00, e}, {8'h00, reg_rdata});
        @(posedge ref_clk) #1;
    endtask

    // low then high on consecutive edges, strobe held across both
    task automatic wr16(input logic [4:0] a, input logic [15:0] v);
        reg_addr = a;
        reg_wdata = v[7:0];
        reg_wr = 1'b1;
        @(posedge ref_clk) #1;
        reg_addr = a + 5'h01;
        reg_wdata = v[15:8];
        @(posedge ref_clk) #1;
        reg_wr = 1'b0;
        @(posedge ref_clk) #1;
    endtask

    task automatic rd16(input logic [4:0] a, input logic [15:0] e, input string what);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk) #1;
        got[7:0] = reg_rdata;
        reg_addr = a + 5'h01;
        @(posedge ref_clk) #1;
        got[15:8] = reg_rdata;
        reg_rd = 1'b0;
        cmp(what, e, got);
        @(posedge ref_clk) #1;
    endtask

    task automatic ww(input logic [1:0] s, input logic [15:0] v);
        word_sel = s;
        word_wdata = v;
        word_wr = 1'b1;
        @(posedge ref_clk) #1;
        word_wr = 1'b0;
        @(posedge ref_clk) #1;
    endtask

    task automatic wrd(input logic [1:0] s, input logic [15:0] e, input string what);
        word_sel = s;
        word_rd = 1'b1;
        @(posedge ref_clk) #1;
        word_rd = 1'b0;
        cmp(what, e, word_rdata);
        @(posedge ref_clk) #1;
    endtask

    task automatic pulse(input logic [4:0] v);
        {trigger_input, pwm_clear_event} = v;
        @(posedge ref_clk) #1;
        {trigger_input, pwm_clear_event} = 5'h00;
        @(posedge ref_clk) #1;
    endtask

    // bounded wait on event b (0) or carry out (1), then freeze the prescaler
    task automatic wait_hit(input bit carry);
        for (int i = 0; i < 100 && !(carry ? cascade_carry_out : event_b); i++)
            @(posedge ref_clk) #1;
        run_steps = 1'b0;
        cmp("awaited pulse", 16'h1, {15'h0, carry ? cascade_carry_out : event_b});
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end

    initial begin
        {rst_b, reg_wr, reg_rd, word_wr, word_rd, count_down, trigger_input} = 7'h00;
        {cascade_carry_in, pin_a_in, pin_b_in, run_steps} = 4'h0;
        {reg_addr, reg_wdata, word_sel, word_wdata} = 31'h0;
        pwm_clear_event = 4'h0;
        comparator_out = 6'h00;
        repeat (2) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        rd16(`OFS_COUNT_LO, 16'h0000, "count at reset");
        rd8(`OFS_MODE, 8'h00, "mode at reset");
        wr16(`OFS_COUNT_LO, 16'h12FE);
        rd16(`OFS_COUNT_LO, 16'h12FE, "count written");
        rd8(`OFS_COUNT_LO, 8'hFE, "count lo");
        wr16(`OFS_COUNT_LO, 16'h3456);
        rd8(`OFS_COUNT_HI, 8'h12, "count hi latched");
        for (int i = 0; i < 4; i++) begin
            ww(i[1:0], 16'hA1C3 + 16'(i));
            rd16(5'(`OFS_CMP_A_LO + 2 * i), 16'hA1C3 + 16'(i), "word via bytes");
        end
        rd8(`OFS_CMP_A_LO, 8'hC3, "compare a lo");
        ww(2'h0, 16'h1111);
        rd8(`OFS_CMP_A_HI, 8'hA1, "compare a hi latched");
        wr8(`OFS_CMP_B_LO, 8'h55);
        wrd(2'h1, 16'hA1C4, "compare b before hi");
        wr8(`OFS_CMP_B_HI, 8'h66);
        wrd(2'h1, 16'h6655, "compare b after hi");
        wr8(5'h1F, 8'hAA);
        rd8(5'h1F, 8'h00, "unmapped offset");
        // compare walk: match a at 1, match b at 3 clears, pin b high then clear low
        wr16(`OFS_COUNT_LO, 16'h0000);
        ww(2'h0, 16'h0001);
        ww(2'h1, 16'h0003);
        wr8(`OFS_OUT_CTRL_B, 8'h1A);
        cmp("pin b initial", 16'h1, {15'h0, io_pin_b});
        wr8(`OFS_MATCH_CTRL, 8'h0F);
        wr8(`OFS_MODE, 8'h07);
        run_steps = 1'b1;
        wait_hit(1'b0);
        cmp("pin b after clear", 16'h0, {15'h0, io_pin_b});
        cmp("event a count", 16'h1, 16'(n_ev_a));
        rd16(`OFS_COUNT_LO, 16'h0000, "count auto cleared");
        rd8(`OFS_STATUS, 8'h03, "match flags");
        wr8(`OFS_STATUS, 8'h01);
        rd8(`OFS_STATUS, 8'h02, "flag a cleared");
        wr8(`OFS_STATUS, 8'h02);
        // free run wrap with pin a set high by the clear action
        wr8(`OFS_MATCH_CTRL, 8'h00);
        wr8(`OFS_MODE, 8'h01);
        wr8(`OFS_OUT_CTRL_A, 8'h21);
        wr16(`OFS_COUNT_LO, 16'hFFFE);
        run_steps = 1'b1;
        wait_hit(1'b1);
        cmp("pin a after wrap", 16'h1, {15'h0, io_pin_a});
        rd16(`OFS_COUNT_LO, 16'h0000, "count wrapped");
        rd8(`OFS_STATUS, 8'h04, "overflow flag");
        rd8(`OFS_OUT_CTRL_A, 8'h20, "initial field reads zero");
        // each pwm and trigger clear source, with an unselected neighbour first
        wr8(`OFS_MODE, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr8(`OFS_CLEAR_SEL, 8'(1 << i));
            wr16(`OFS_COUNT_LO, 16'h0050);
            pulse(5'(1 << ((i + 1) % 5)));
            rd16(`OFS_COUNT_LO, 16'h0050, "count kept");
            pulse(5'(1 << i));
            rd16(`OFS_COUNT_LO, 16'h0000, "count cleared");
        end
        // initial level write meets a trigger clear: pin a takes the initial low
        reg_addr = `OFS_OUT_CTRL_A;
        reg_wdata = 8'h21;
        {reg_wr, trigger_input} = 2'b11;
        @(posedge ref_clk) #1;
        {reg_wr, trigger_input} = 2'b00;
        cmp("pin a init over clear", 16'h0, {15'h0, io_pin_a});
        @(posedge ref_clk) #1;
        // high byte write meets a trigger clear in the same cycle
        wr8(`OFS_COUNT_LO, 8'h77);
        reg_addr = `OFS_COUNT_HI;
        reg_wdata = 8'h00;
        {reg_wr, trigger_input} = 2'b11;
        @(posedge ref_clk) #1;
        {reg_wr, trigger_input} = 2'b00;
        cmp("pin a clear under write", 16'h1, {15'h0, io_pin_a});
        rd16(`OFS_COUNT_LO, 16'h0077, "write beats clear");
        // cascade: the count steps down on the carry input alone
        wr8(`OFS_MODE, 8'h09);
        {cascade_carry_in, count_down} = 2'b11;
        @(posedge ref_clk) #1;
        {cascade_carry_in, count_down} = 2'b00;
        rd16(`OFS_COUNT_LO, 16'h0076, "cascade down step");
        // phase input source: comparator 4/5 versus pins on channel 0
        comparator_out = 6'b010000;
        pin_b_in = 1'b1;
        wr8(`OFS_PHASE_SEL, 8'h01);
        cmp("phase a source", 16'h1, {15'h0, phase_a_src});
        cmp("phase b source", 16'h1, {15'h0, phase_b_src});
        wr8(`OFS_PHASE_SEL, 8'h02);
        cmp("phase a pin", 16'h0, {15'h0, phase_a_src});
        cmp("phase b comparator", 16'h0, {15'h0, phase_b_src});
        rd8(`OFS_PHASE_SEL, 8'h02, "phase select");
        end_of_test();
    end
endmodule
`default_nettype wire
